// File: hw/ulsf_pkg.sv
/*
  ulsf_pkg: constants and types for the receive line status flag block.
  Assumes: one clock domain, AHB-Lite register access with 32-bit words.
*/
package ulsf_pkg;
  // character and fifo geometry
  localparam int ULSF_DATA_W = 8;
  localparam int ULSF_DEPTH = 16;
  localparam int ULSF_PTR_W = 4;
  localparam int ULSF_CNT_W = 5;
  localparam logic [ULSF_PTR_W-1:0] ULSF_PTR_ONE = 4'h1;
  localparam logic [ULSF_CNT_W-1:0] ULSF_CNT_ONE = 5'h01;
  localparam logic [ULSF_CNT_W-1:0] ULSF_CNT_ZERO = 5'h00;
  // capacity in fifo mode and in single holding register mode
  localparam logic [ULSF_CNT_W-1:0] ULSF_CAP_FIFO = 5'h10;
  localparam logic [ULSF_CNT_W-1:0] ULSF_CAP_HOLD = 5'h01;

  // register byte offsets (low address byte only is decoded)
  localparam logic [7:0] ULSF_OFF_RX_DATA = 8'h00;
  localparam logic [7:0] ULSF_OFF_LINE_STATUS = 8'h04;
  localparam logic [7:0] ULSF_OFF_CONTROL = 8'h08;
  localparam logic [7:0] ULSF_OFF_INT_STATUS = 8'h0C;
  localparam logic [7:0] ULSF_OFF_INT_CLEAR = 8'h10;
  localparam logic [7:0] ULSF_OFF_INT_ENABLE = 8'h14;
  localparam logic [7:0] ULSF_OFF_SHIFT = 8'h18;

  // line status bit positions
  localparam int ULSF_LSR_READY_BIT = 0;
  localparam int ULSF_LSR_OVERRUN_BIT = 1;
  localparam int ULSF_LSR_PARITY_BIT = 2;
  localparam int ULSF_LSR_FIFO_ERR_BIT = 7;

  // control register
  localparam int ULSF_CTRL_FIFO_EN_BIT = 0;
  localparam logic [7:0] ULSF_CTRL_RESET = 8'h00;

  // interrupt event bits, shared by status, clear and enable
  localparam int ULSF_EV_W = 3;
  localparam int ULSF_EV_RX = 0;
  localparam int ULSF_EV_OVR = 1;
  localparam int ULSF_EV_PAR = 2;
  localparam logic [ULSF_EV_W-1:0] ULSF_EV_RESET = 3'h0;

  // misc reset values
  localparam logic [31:0] ULSF_WORD_ZERO = 32'h00000000;
  localparam logic [7:0] ULSF_BYTE_ZERO = 8'h00;
  localparam logic ULSF_RESP_OKAY = 1'b0;

  // one queued character with its error marks
  typedef struct packed {
    logic brk;
    logic frm;
    logic par;
    logic [ULSF_DATA_W-1:0] data;
  } ulsf_entry_t;
endpackage : ulsf_pkg

// File: hw/ulsf_fifo_if.sv
/*
  ulsf_fifo_if: signals between the status logic and the receive fifo.
  Assumes: both ends on the same clock.
*/
`timescale 1ns/1ns
interface ulsf_fifo_if;
  logic push; // write one character
  ulsf_pkg::ulsf_entry_t push_data; // character and error marks
  logic pop; // drop the head character
  logic [ulsf_pkg::ULSF_CNT_W-1:0] cap; // current capacity
  ulsf_pkg::ulsf_entry_t head; // character at the head
  logic [ulsf_pkg::ULSF_CNT_W-1:0] count; // characters held
  logic full; // count has reached capacity
  modport ctrl (output push, output push_data, output pop, output cap,
                input head, input count, input full);
  modport store (input push, input push_data, input pop, input cap,
                 output head, output count, output full);
endinterface : ulsf_fifo_if

// File: hw/ulsf_rx_fifo.sv
/*
  ulsf_rx_fifo: 16-entry receive fifo holding characters with error marks.
  Assumes: the caller never pushes when full; a push while full is dropped.
*/
`timescale 1ns/1ns
module ulsf_rx_fifo (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // fifo port
  ulsf_fifo_if.store fif
);
  ulsf_pkg::ulsf_entry_t mem_q [ulsf_pkg::ULSF_DEPTH]; // storage, no reset needed
  logic [ulsf_pkg::ULSF_PTR_W-1:0] wp_q; // write pointer
  logic [ulsf_pkg::ULSF_PTR_W-1:0] rp_q; // read pointer
  logic [ulsf_pkg::ULSF_CNT_W-1:0] cnt_q; // occupancy
  logic [ulsf_pkg::ULSF_CNT_W-1:0] cnt_d;
  wire do_push;
  wire do_pop;

  // full compares against capacity so leaving fifo mode with data queued still blocks
  assign fif.full = (cnt_q >= fif.cap);
  assign fif.count = cnt_q;
  assign fif.head = mem_q[rp_q];
  assign do_push = fif.push & ~fif.full;
  assign do_pop = fif.pop & (cnt_q != ulsf_pkg::ULSF_CNT_ZERO);
  assign cnt_d = (do_push & ~do_pop) ? cnt_q + ulsf_pkg::ULSF_CNT_ONE :
                 (do_pop & ~do_push) ? cnt_q - ulsf_pkg::ULSF_CNT_ONE : cnt_q;

  // storage write, data only
  always_ff @(posedge i_clock) begin
    if (do_push) begin
      mem_q[wp_q] <= fif.push_data;
    end
  end

  // pointers and occupancy
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= ulsf_pkg::ULSF_CNT_ZERO;
    end else begin
      wp_q <= do_push ? wp_q + ulsf_pkg::ULSF_PTR_ONE : wp_q;
      rp_q <= do_pop ? rp_q + ulsf_pkg::ULSF_PTR_ONE : rp_q;
      cnt_q <= cnt_d;
    end
  end
endmodule : ulsf_rx_fifo

// File: hw/ulsf_line_status.sv
/*
  ulsf_line_status: receive line status flags with an AHB-Lite register file,
  the receive shift register copy, the receive fifo and a level interrupt.
  Assumes: the receiver core gives a one-cycle pulse per finished character,
  with its error marks, on this clock; single word AHB-Lite transfers.
*/
// Added by the designer: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ns
module ulsf_line_status (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // ahb-lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic i_hready,
  input wire logic [31:0] i_hwdata,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  // receiver core
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_char,
  input wire logic i_rx_parity_err,
  input wire logic i_rx_frame_err,
  input wire logic i_rx_break,
  // interrupt
  output logic o_irq
);
  // decode of the low address byte against a register offset
  function automatic logic at_off(input logic [31:0] addr, input logic [7:0] off);
    at_off = (addr[7:0] == off);
  endfunction : at_off

  ulsf_fifo_if fif(); // link to the fifo

  // register map, one 32-bit word per register, byte addresses:
  //   rx data     read pops the head character, empty reads zero
  //   line status ready, overrun, head parity and fifo error flags
  //   control     bit 0 selects the 16-deep fifo, clear gives depth one
  //   int status  sticky events: queued, overrun, queued with bad parity
  //   int clear   write ones to drop status bits, reads zero
  //   int enable  same layout as the status
  //   shift copy  last finished character, kept even on overrun
  // only the low address byte is decoded, so the map repeats every 256 bytes

  // register state
  logic [7:0] ctrl_q; // control, bit 0 selects fifo mode
  logic overrun_q; // overrun flag
  logic fde_q; // fifo data error flag
  logic [7:0] shift_q; // copy of the receive shift register
  logic [ulsf_pkg::ULSF_EV_W-1:0] ist_q; // sticky interrupt status
  logic [ulsf_pkg::ULSF_EV_W-1:0] ien_q; // interrupt enable
  logic wr_pend_q; // write data phase pending
  logic [31:0] wr_addr_q; // address of pending write
  logic [31:0] hrdata_q; // read data register
  logic irq_q; // interrupt level
  logic overrun_d;
  logic fde_d;
  logic [ulsf_pkg::ULSF_EV_W-1:0] ist_d;
  logic [7:0] lsr_v; // line status value as it reads now

  // address phase decode
  wire addr_ok = i_hsel & i_htrans[1] & i_hready;
  wire rd_req = addr_ok & ~i_hwrite;
  wire wr_req = addr_ok & i_hwrite;
  wire rd_data = rd_req & at_off(i_haddr, ulsf_pkg::ULSF_OFF_RX_DATA);
  wire rd_lsr = rd_req & at_off(i_haddr, ulsf_pkg::ULSF_OFF_LINE_STATUS);
  // data phase write strobes
  wire wr_ctrl = wr_pend_q & at_off(wr_addr_q, ulsf_pkg::ULSF_OFF_CONTROL);
  wire wr_iclr = wr_pend_q & at_off(wr_addr_q, ulsf_pkg::ULSF_OFF_INT_CLEAR);
  wire wr_ien = wr_pend_q & at_off(wr_addr_q, ulsf_pkg::ULSF_OFF_INT_ENABLE);

  // receive path
  wire fifo_en = ctrl_q[ulsf_pkg::ULSF_CTRL_FIFO_EN_BIT];
  wire has_data = (fif.count != ulsf_pkg::ULSF_CNT_ZERO);
  wire arrive_full = i_rx_valid & fif.full; // overrun event
  wire arrive_ok = i_rx_valid & ~fif.full; // normal transfer into the queue
  wire in_err = i_rx_parity_err | i_rx_frame_err | i_rx_break;
  // the fifo error flag is a sticky latch set on push, not a scan of the queue,
  // so a status read can clear it while marked characters still wait
  wire par_event = arrive_ok & i_rx_parity_err;
  wire [ulsf_pkg::ULSF_EV_W-1:0] ev_vec = {par_event, arrive_full, arrive_ok};
  wire [ulsf_pkg::ULSF_EV_W-1:0] clr_vec =
    wr_iclr ? i_hwdata[ulsf_pkg::ULSF_EV_W-1:0] : ulsf_pkg::ULSF_EV_RESET;
  // non-fifo mode behaves as a one-deep holding register
  assign fif.cap = fifo_en ? ulsf_pkg::ULSF_CAP_FIFO : ulsf_pkg::ULSF_CAP_HOLD;
  // an overrun arrival never reaches the queue
  assign fif.push = arrive_ok;
  assign fif.push_data = '{brk: i_rx_break, frm: i_rx_frame_err,
                           par: i_rx_parity_err, data: i_rx_char};
  // a read of the data register drops the head character
  assign fif.pop = rd_data & has_data;

  ulsf_rx_fifo u_fifo (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .fif(fif.store)
  );

  // in holding register mode the head is the only character, so the same
  // head based parity also serves the non-fifo case
  // an empty queue forces ready and parity low whatever the stale head holds
  // line status value; parity always follows the head entry
  always_comb begin
    lsr_v = ulsf_pkg::ULSF_BYTE_ZERO;
    lsr_v[ulsf_pkg::ULSF_LSR_READY_BIT] = has_data;
    lsr_v[ulsf_pkg::ULSF_LSR_OVERRUN_BIT] = overrun_q;
    lsr_v[ulsf_pkg::ULSF_LSR_PARITY_BIT] = has_data & fif.head.par;
    lsr_v[ulsf_pkg::ULSF_LSR_FIFO_ERR_BIT] = fde_q;
  end

  // read data select; unmapped and write-only offsets read zero
  wire [7:0] rx_byte = has_data ? fif.head.data : ulsf_pkg::ULSF_BYTE_ZERO;
  wire [31:0] rd_mux =
    at_off(i_haddr, ulsf_pkg::ULSF_OFF_RX_DATA) ? {24'h000000, rx_byte} :
    at_off(i_haddr, ulsf_pkg::ULSF_OFF_LINE_STATUS) ? {24'h000000, lsr_v} :
    at_off(i_haddr, ulsf_pkg::ULSF_OFF_CONTROL) ? {24'h000000, ctrl_q} :
    at_off(i_haddr, ulsf_pkg::ULSF_OFF_INT_STATUS) ? {29'h0, ist_q} :
    at_off(i_haddr, ulsf_pkg::ULSF_OFF_INT_ENABLE) ? {29'h0, ien_q} :
    at_off(i_haddr, ulsf_pkg::ULSF_OFF_SHIFT) ? {24'h000000, shift_q} :
    ulsf_pkg::ULSF_WORD_ZERO;

  // flag next values; a new event wins over a clear in the same cycle
  assign overrun_d = arrive_full | (overrun_q & ~rd_lsr);
  assign fde_d = (arrive_ok & in_err & fifo_en) | (fde_q & ~rd_lsr);
  assign ist_d = ev_vec | (ist_q & ~clr_vec);

  // line status flags
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      overrun_q <= 1'b0;
      fde_q <= 1'b0;
    end else begin
      overrun_q <= overrun_d;
      fde_q <= fde_d;
    end
  end

  // trade-off: the copy is a plain byte register, not part of the queue, so
  // software can still see what an overrun threw away
  // shift register copy takes every finished character, full or not
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      shift_q <= ulsf_pkg::ULSF_BYTE_ZERO;
    end else if (i_rx_valid) begin
      shift_q <= i_rx_char;
    end
  end

  // the interrupt output lags the status by one edge; software polling the
  // status word sees an event one cycle before the pin does
  // control and interrupt registers
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ctrl_q <= ulsf_pkg::ULSF_CTRL_RESET;
      ien_q <= ulsf_pkg::ULSF_EV_RESET;
      ist_q <= ulsf_pkg::ULSF_EV_RESET;
      irq_q <= 1'b0;
    end else begin
      ctrl_q <= wr_ctrl ? i_hwdata[7:0] : ctrl_q;
      ien_q <= wr_ien ? i_hwdata[ulsf_pkg::ULSF_EV_W-1:0] : ien_q;
      ist_q <= ist_d;
      // one cycle behind the status so the output is a plain flop
      irq_q <= |(ist_q & ien_q);
    end
  end

  // bus phases: zero wait states, read data loaded at the address edge
  // a write is only remembered at its address edge; the register itself changes
  // at the data edge, so a read straight after a write to the same word still
  // returns the old contents
  // read side effects (pop, flag clear) happen at the address edge as well,
  // which keeps them tied to the one read that the master actually issued
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= ulsf_pkg::ULSF_WORD_ZERO;
      hrdata_q <= ulsf_pkg::ULSF_WORD_ZERO;
    end else begin
      wr_pend_q <= wr_req;
      wr_addr_q <= wr_req ? i_haddr : wr_addr_q;
      hrdata_q <= rd_req ? rd_mux : hrdata_q;
    end
  end

  // outputs straight from flops; ready and response are constant flops
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_hreadyout <= 1'b1;
      o_hresp <= ulsf_pkg::ULSF_RESP_OKAY;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp <= ulsf_pkg::ULSF_RESP_OKAY;
    end
  end
  assign o_hrdata = hrdata_q;
  assign o_irq = irq_q;

  // checks on the flag behaviour
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  sequence s_full_arrival;
    i_rx_valid && fif.full;
  endsequence
  sequence s_lsr_read;
    rd_lsr && !(i_rx_valid && fif.full);
  endsequence
  sequence s_bad_push;
    i_rx_valid && !fif.full && i_rx_parity_err;
  endsequence

  a_overrun_set: assert property (s_full_arrival |=> overrun_q)
    else $error("overrun flag not set after arrival into full fifo");
  a_overrun_clear: assert property (s_lsr_read |=> !overrun_q)
    else $error("overrun flag survived a status read");
  a_full_no_push: assert property (s_full_arrival ##0 !fif.pop
                                   |=> fif.count == $past(fif.count))
    else $error("fifo count changed on overrun arrival");
  a_shift_replace: assert property (i_rx_valid |=> shift_q == $past(i_rx_char))
    else $error("shift register copy not replaced by arrival");
  a_parity_read: assert property (rd_lsr |=>
    o_hrdata[ulsf_pkg::ULSF_LSR_PARITY_BIT] == $past(has_data && fif.head.par))
    else $error("status read parity bit does not match head entry");
  a_parity_set: assert property (s_bad_push ##0 (fif.count == ulsf_pkg::ULSF_CNT_ZERO)
    |=> lsr_v[ulsf_pkg::ULSF_LSR_PARITY_BIT])
    else $error("parity flag not set for bad character at head");
  a_ready_clear: assert property ((fif.count == ulsf_pkg::ULSF_CNT_ONE) && fif.pop
    && !i_rx_valid |=> !lsr_v[ulsf_pkg::ULSF_LSR_READY_BIT] [*1])
    else $error("ready flag still high with empty fifo");
  a_ready_set: assert property (i_rx_valid && !fif.full && !fif.pop
    |=> lsr_v[ulsf_pkg::ULSF_LSR_READY_BIT])
    else $error("ready flag low after a character was queued");
  a_fde_set: assert property (i_rx_valid && !fif.full && fifo_en && in_err
    |=> fde_q)
    else $error("fifo data error flag not set");
  a_fde_clear: assert property (rd_lsr && !(i_rx_valid && in_err) |=> !fde_q)
    else $error("fifo data error flag not cleared by status read");
  a_irq_level: assert property ((|(ist_q & ien_q)) |=> o_irq)
    else $error("interrupt not raised for enabled status");

  // receive side: reading the data word drops exactly one character
  sequence s_data_read;
    rd_data && has_data;
  endsequence
  sequence s_quiet_line;
    !i_rx_valid;
  endsequence

  // status read returns every flag as it stood at the address edge
  a_ready_read: assert property (rd_lsr |=>
    o_hrdata[ulsf_pkg::ULSF_LSR_READY_BIT] == $past(has_data))
    else $error("status read ready bit does not match queue");
  a_overrun_read: assert property (rd_lsr |=>
    o_hrdata[ulsf_pkg::ULSF_LSR_OVERRUN_BIT] == $past(overrun_q))
    else $error("status read overrun bit does not match flag");
  a_fde_read: assert property (rd_lsr |=>
    o_hrdata[ulsf_pkg::ULSF_LSR_FIFO_ERR_BIT] == $past(fde_q))
    else $error("status read error bit does not match flag");

  // flags are sticky until read and stay low without a cause
  a_overrun_hold: assert property (overrun_q && !rd_lsr |=> overrun_q)
    else $error("overrun flag dropped without a status read");
  a_overrun_quiet: assert property (!overrun_q && !(i_rx_valid && fif.full)
    |=> !overrun_q)
    else $error("overrun flag set without an overrun");
  a_fde_hold: assert property (fde_q && !rd_lsr |=> fde_q)
    else $error("fifo data error flag dropped without a status read");
  a_fde_quiet: assert property (!fde_q && !(i_rx_valid && in_err) |=> !fde_q)
    else $error("fifo data error flag set without a marked character");

  // overrun leaves the queued characters alone and is recorded as an event
  a_full_head_kept: assert property (s_full_arrival ##0 !fif.pop
    |=> fif.head == $past(fif.head))
    else $error("head character changed on overrun arrival");
  a_overrun_event: assert property (s_full_arrival
    |=> ist_q[ulsf_pkg::ULSF_EV_OVR])
    else $error("overrun event not recorded in interrupt status");

  // a data read with no arrival shrinks the queue by one
  a_pop_count: assert property (s_data_read ##0 s_quiet_line
    |=> fif.count == $past(fif.count) - ulsf_pkg::ULSF_CNT_ONE)
    else $error("data read did not drop exactly one character");

  // bus side: zero wait states, always OKAY, read data held between reads
  a_bus_okay: assert property (o_hreadyout && (o_hresp == ulsf_pkg::ULSF_RESP_OKAY))
    else $error("slave not ready or response not OKAY");
  a_rdata_hold: assert property (!rd_req |=> $stable(o_hrdata))
    else $error("read data changed without a read");
  a_ctrl_write: assert property (wr_ctrl |=> ctrl_q == $past(i_hwdata[7:0]))
    else $error("control write did not land");
  a_irq_low: assert property (!(|(ist_q & ien_q)) |=> !o_irq)
    else $error("interrupt raised with no enabled status");
endmodule : ulsf_line_status

// File: testbench/ulsf_char_src.sv
/*
  ulsf_char_src: model of the remote transmitter as seen through the receiver core,
  one pulse per finished character with its error marks.
  Assumes: the same clock as the status block; driven only by its send task.
*/
`timescale 1ns/1ns
module ulsf_char_src (
  // clock
  input wire logic i_clock,
  // finished character toward the status block
  output logic o_valid,
  output logic [7:0] o_char,
  output logic o_par,
  output logic o_frm,
  output logic o_brk
);
  // idle at time zero, no character pending
  initial begin
    o_valid = 1'b0;
    o_char = 8'hA5;
    o_par = 1'b0;
    o_frm = 1'b0;
    o_brk = 1'b0;
  end

  // n characters back to back, counting up from c, all with the same marks
  task automatic send(input logic [7:0] c, input logic p, input logic f, input logic b,
                      input int n);
    logic [7:0] ch;
    ch = c;
    repeat (n) begin
      @(posedge i_clock);
      o_valid <= 1'b1;
      o_char <= ch;
      o_par <= p;
      o_frm <= f;
      o_brk <= b;
      ch = ch + 8'h01;
    end
    @(posedge i_clock);
    o_valid <= 1'b0;
    // lines are not held after the pulse: show the inverse, never the old value
    o_char <= ~(ch - 8'h01);
    o_par <= ~p;
    o_frm <= ~f;
    o_brk <= ~b;
  endtask : send
endmodule : ulsf_char_src

// File: testbench/uart_rx_line_status_flags_bench.sv
/*
  uart_rx_line_status_flags_bench: self-checking bench for the line status block.
  Assumes: one clock, AHB-Lite single word transfers, hready fed back from hreadyout.
*/
`timescale 1ns/1ns
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value %s expected %0h seen %0h", nm, (e), (g)); end end
module uart_rx_line_status_flags_bench;
  // register byte offsets, short aliases of the package constants
  localparam logic [7:0] LS = ulsf_pkg::ULSF_OFF_LINE_STATUS;
  localparam logic [7:0] RXD = ulsf_pkg::ULSF_OFF_RX_DATA;
  localparam logic [7:0] CTL = ulsf_pkg::ULSF_OFF_CONTROL;
  localparam logic [7:0] IST = ulsf_pkg::ULSF_OFF_INT_STATUS;
  localparam logic [7:0] ICL = ulsf_pkg::ULSF_OFF_INT_CLEAR;
  localparam logic [7:0] IEN = ulsf_pkg::ULSF_OFF_INT_ENABLE;
  localparam logic [7:0] SHF = ulsf_pkg::ULSF_OFF_SHIFT;
  logic clock = 1'b0; // 125 MHz
  logic rst = 1'b1; // synchronous, active high
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2; // word transfers only
  logic [31:0] hwdata = 32'h00000000;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic irq;
  logic rx_valid;
  logic [7:0] rx_char;
  logic rx_par;
  logic rx_frm;
  logic rx_brk;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #4 clock = ~clock;

  ulsf_char_src u_src (.i_clock(clock), .o_valid(rx_valid), .o_char(rx_char),
    .o_par(rx_par), .o_frm(rx_frm), .o_brk(rx_brk));
  ulsf_line_status u_dut (.i_clock(clock), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hready(hreadyout),
    .i_hwdata(hwdata), .o_hreadyout(hreadyout), .o_hresp(hresp), .o_hrdata(hrdata),
    .i_rx_valid(rx_valid), .i_rx_char(rx_char), .i_rx_parity_err(rx_par),
    .i_rx_frame_err(rx_frm), .i_rx_break(rx_brk), .o_irq(irq));

  // closing report, reached from the main sequence or the hang guard
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end
  end

  // one single transfer: address phase held until hready, then data phase until hready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
    `CHK("hresp", ulsf_pkg::ULSF_RESP_OKAY, hresp)
  endtask : bus

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] v;
    bus(1'b0, a, 32'h00000000, v);
    `CHK(nm, e, v)
  endtask : rd_chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    bus(1'b1, a, d, v);
  endtask : wr

  // values straight after reset, plus an unmapped offset
  task automatic t_reset();
    rd_chk(LS, 32'h00000000, "line_status at reset");
    rd_chk(8'h1C, 32'h00000000, "unmapped offset");
    `CHK("irq at reset", 1'b0, irq)
    `CHK("hreadyout at reset", 1'b1, hreadyout)
  endtask : t_reset

  // single holding register mode: ready, overrun into a full holder, parity
  task automatic t_single();
    u_src.send(8'h3C, 1'b0, 1'b0, 1'b0, 1);
    rd_chk(LS, 32'h00000001, "ready only");
    u_src.send(8'h5A, 1'b1, 1'b0, 1'b0, 1);
    rd_chk(SHF, 32'h0000005A, "shift copy");
    rd_chk(LS, 32'h00000003, "overrun set");
    rd_chk(LS, 32'h00000001, "overrun cleared");
    rd_chk(RXD, 32'h0000003C, "held char");
    rd_chk(LS, 32'h00000000, "holder empty");
    u_src.send(8'hC3, 1'b1, 1'b0, 1'b0, 1);
    rd_chk(LS, 32'h00000005, "parity set");
    rd_chk(RXD, 32'h000000C3, "bad char");
    rd_chk(LS, 32'h00000000, "parity gone");
  endtask : t_single

  // fifo mode: fill to full back to back, overrun, head parity, error flag read-clear
  task automatic t_fifo();
    wr(CTL, 32'h00000001);
    rd_chk(CTL, 32'h00000001, "control readback");
    u_src.send(8'h10, 1'b1, 1'b0, 1'b0, 1);
    u_src.send(8'h11, 1'b0, 1'b0, 1'b0, 15);
    rd_chk(LS, 32'h00000085, "full, bad head");
    rd_chk(LS, 32'h00000005, "error flag read");
    u_src.send(8'hEE, 1'b0, 1'b0, 1'b0, 1);
    rd_chk(LS, 32'h00000007, "fifo overrun");
    rd_chk(SHF, 32'h000000EE, "overwritten copy");
    rd_chk(RXD, 32'h00000010, "first char");
    rd_chk(LS, 32'h00000001, "good head");
    // newest char is bad but the head is good, so parity must stay low
    u_src.send(8'h77, 1'b1, 1'b0, 1'b0, 1);
    rd_chk(LS, 32'h00000081, "bad tail");
    for (int i = 0; i < 15; i++) begin
      rd_chk(RXD, 32'(32'h11 + i), "queued char");
    end
    rd_chk(LS, 32'h00000005, "bad char at head");
    rd_chk(RXD, 32'h00000077, "last char");
    rd_chk(LS, 32'h00000000, "fifo empty");
    // framing and break marks also raise the fifo error flag
    for (int k = 0; k < 2; k++) begin
      u_src.send(8'h40, k == 0, k == 1, 1'b0, 1);
      u_src.send(8'h40, 1'b0, k == 0, k == 1, 1);
      rd_chk(LS, 32'h00000081 | 32'(k == 0) << 2, "mark error flag");
      rd_chk(RXD, 32'h00000040, "mark char a");
      rd_chk(RXD, 32'h00000040, "mark char b");
    end
  endtask : t_fifo

  // interrupt: raise while masked, enable, clear
  task automatic t_irq();
    wr(ICL, 32'h00000007);
    rd_chk(IST, 32'h00000000, "status cleared");
    wr(IEN, 32'h00000000);
    u_src.send(8'h21, 1'b1, 1'b0, 1'b0, 1);
    rd_chk(IST, 32'h00000005, "events sticky");
    `CHK("irq masked", 1'b0, irq)
    wr(IEN, 32'h00000004);
    repeat (2) @(posedge clock);
    `CHK("irq raised", 1'b1, irq)
    rd_chk(IEN, 32'h00000004, "enable readback");
    wr(ICL, 32'h00000004);
    repeat (2) @(posedge clock);
    `CHK("irq cleared", 1'b0, irq)
    rd_chk(IST, 32'h00000001, "other event kept");
    rd_chk(RXD, 32'h00000021, "irq char");
  endtask : t_irq

  // main sequence: reset for two cycles, then every scenario
  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_reset();
    t_single();
    t_fifo();
    t_irq();
    give_verdict();
  end
endmodule : uart_rx_line_status_flags_bench
